// ### core/spi_port_defs.svh
// Constants for the SPI register access port: offsets, fields, counts.
// Assumes inclusion by bare name ahead of the package and design modules.
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// ----------------------------------------
// Frame lengths and check value
// ----------------------------------------
`define SPI_LEN_BASE     5'h10
`define SPI_LEN_CRC      5'h14
`define SPI_CNT_MAX      5'h1f
`define SPI_CRC_INIT     4'hf
`define SPI_CRC_POLY     4'h3
`define SPI_SCLK_MAX_MHZ 10

// ----------------------------------------
// Frame fields (16-bit payload)
// ----------------------------------------
`define F_SYNC 15
`define F_RW   14

// ----------------------------------------
// Primary word indices (byte address / 2)
// ----------------------------------------
`define W_NOP       5'h00
`define W_WR_ADDR   5'h01
`define W_WR_MSB    5'h02
`define W_WR_LSB    5'h03
`define W_WR_STAT   5'h04
`define W_RD_ADDR   5'h05
`define W_RD_STAT   5'h06
`define W_RD_MSB    5'h07
`define W_RD_LSB    5'h08
`define W_OUT_FIRST 5'h0e
`define W_ANGLE     5'h15
`define W_LP_RD_END 5'h15
`define W_OUT_LAST  5'h18
`define W_CFG       5'h19

// ----------------------------------------
// Status fields and extended memory
// ----------------------------------------
`define EX_GO_BIT   7
`define EX_DONE_VAL 16'h0001
`define EXT_AW      4
`define EXT_DEPTH   16

`endif

// ### core/spi_port_pkg.sv
// Types shared by the SPI register access port.
// Assumes spi_port_defs.svh is compiled alongside.
package spi_port_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DECIDE = 2'b01
	} commit_state_t;

	typedef enum logic [2:0] {
		V_NONE    = 3'b000,
		V_WRITE   = 3'b001,
		V_READ    = 3'b010,
		V_IGNORED = 3'b011,
		V_CRC_ERR = 3'b100
	} verdict_t;

endpackage

// ### core/crc4_word.sv
// Combinational 4-bit CRC over a word, most significant bit first.
// Assumes the caller holds the data stable while the result is used.
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module crc4_word #(
	parameter logic [3:0] POLY = `SPI_CRC_POLY,
	parameter int         N    = 16
) (
	input  wire logic [N-1:0] data_i,
	output logic      [3:0]   crc_o
);

	logic [3:0] chain [0:N];

	assign chain[0] = `SPI_CRC_INIT;

	genvar i;
	for (i = 0; i < N; i++) begin : g_step
		logic fb;
		assign fb = chain[i][3] ^ data_i[N-1-i];
		assign chain[i+1] = {chain[i][2:0], 1'b0} ^ (fb ? POLY : 4'h0);
	end

	assign crc_o = chain[N];

endmodule // crc4_word

// ### core/spi_link_shift.sv
// Serial-clock side of the port: shifts MOSI in, MISO out.
// Assumes tx_word_i is only changed while chip select is high.
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_link_shift (
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic        rst_n_i,
	input  wire logic [19:0] tx_word_i,
	output logic      [19:0] rx_frame_o,
	output logic      [4:0]  rx_count_o,
	output logic             frame_tog_o,
	output logic             miso_o,
	output logic             miso_oe_o
);

	logic       started;
	logic [4:0] fidx;
	logic [4:0] next_count;
	logic       tx_bit;

	// ----------------------------------------
	// Receive on rising edges
	// ----------------------------------------
	// Cleared by the frame's own select, since the clock stops between frames
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i)
			started <= 1'b0;
		else
			started <= 1'b1;
	end

	assign next_count = !started ? 5'h01 :
		(rx_count_o == `SPI_CNT_MAX) ? rx_count_o : rx_count_o + 5'h01;

	// Count and data are left standing after select rises for the commit
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_frame_o  <= 20'h00000;
			rx_count_o  <= 5'h00;
			frame_tog_o <= 1'b0;
		end else if (!cs_n_i) begin
			rx_frame_o <= {rx_frame_o[18:0], mosi_i};
			rx_count_o <= next_count;
			if (!started)
				frame_tog_o <= ~frame_tog_o;
		end
	end

	// ----------------------------------------
	// Transmit on falling edges
	// ----------------------------------------
	assign tx_bit = (fidx < `SPI_LEN_CRC) ? tx_word_i[5'h13 - fidx] : 1'b0;

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			fidx      <= 5'h00;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
		end else begin
			miso_oe_o <= 1'b1;
			miso_o    <= tx_bit;
			if (fidx != `SPI_LEN_CRC)
				fidx <= fidx + 5'h01;
		end
	end

endmodule // spi_link_shift

// ### core/spi_register_access_port.sv
// Four-wire SPI peripheral giving byte write and two-stage read access
// to 16-bit primary registers and, indirectly, a 32-bit extended store.
// Assumes chip select stays high at least 6 system clocks between frames.
//
// Function
// - Mode 3: idle high, sample on rise
// - Device is peripheral, drives only MISO
// - Frames are 16 bits, or 20 with check
// - Check bits go out on pulses 17-20
// - Check register starts at all ones
// - Long frames ignored when checking disabled
// - Bad check discards frame, keeps read data
// - MOSI sampled on rising serial clock
// - Frame committed when select rises
// - Write frame returns last read data
// - After write, zeros or angle, by parameter
// - Next frame shifts out selected register
// - MISO changes on falling serial clock
// - Byte registers plus indirect extended access
// - Low power limits reachable registers
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_register_access_port #(
	parameter logic [3:0] CRC_POLY         = `SPI_CRC_POLY,
	parameter bit         WR_RETURNS_ANGLE = 1'b0
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  sclk_i,
	input  wire logic                  cs_n_i,
	input  wire logic                  mosi_i,
	output logic                       miso_o,
	output logic                       miso_oe_o,
	input  wire logic                  crc_en_i,
	input  wire logic                  low_power_i,
	input  wire logic [15:0]           angle_i,
	output logic                       frame_done_o,
	output logic                       crc_err_o,
	output spi_port_pkg::verdict_t     verdict_o
);
	import spi_port_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	assign rst_n = rst_sync[1];

	// ----------------------------------------
	// Serial clock domain
	// ----------------------------------------
	logic [19:0] rx_frame;
	logic [4:0]  rx_count;
	logic        frame_tog;
	logic [19:0] tx_word;

	spi_link_shift u_link (
		.sclk_i      (sclk_i),
		.cs_n_i      (cs_n_i),
		.mosi_i      (mosi_i),
		.rst_n_i     (rst_n),
		.tx_word_i   (tx_word),
		.rx_frame_o  (rx_frame),
		.rx_count_o  (rx_count),
		.frame_tog_o (frame_tog),
		.miso_o      (miso_o),
		.miso_oe_o   (miso_oe_o)
	);

	// ----------------------------------------
	// Crossing: select level and frame toggle
	// ----------------------------------------
	logic [1:0] async_in;
	logic [1:0] meta;
	logic [1:0] synced;
	logic       cs_prev;
	logic       tog_seen;

	// Reset to the idle levels (toggle low, select high), so no false frame follows reset
	localparam logic [1:0] SYNC_IDLE = 2'b01;

	assign async_in = {frame_tog, cs_n_i};

	genvar g;
	for (g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge sys_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				meta[g]   <= SYNC_IDLE[g];
				synced[g] <= SYNC_IDLE[g];
			end else begin
				meta[g]   <= async_in[g];
				synced[g] <= meta[g];
			end
		end
	end

	logic cs_rise;
	logic new_frame;

	assign cs_rise   = synced[0] & ~cs_prev;
	assign new_frame = cs_rise & (synced[1] != tog_seen);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev  <= 1'b1;
			tog_seen <= 1'b0;
		end else begin
			cs_prev <= synced[0];
			if (cs_rise)
				tog_seen <= synced[1];
		end
	end

	// ----------------------------------------
	// Commit sequencer
	// ----------------------------------------
	// Shift data is quiet after select rises, so it is captured as a word
	commit_state_t state;
	commit_state_t next_state;
	logic [19:0]   cap_frame;
	logic [4:0]    cap_count;

	assign next_state = (state == ST_IDLE && new_frame) ? ST_DECIDE : ST_IDLE;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			cap_frame <= 20'h00000;
			cap_count <= 5'h00;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && new_frame) begin
				cap_frame <= rx_frame;
				cap_count <= rx_count;
			end
		end
	end

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	logic        in_decide;
	logic        is_long;
	logic [15:0] payload;
	logic [3:0]  rx_crc;
	logic        len_ok;
	logic        crc_ok;
	logic        accept;
	logic        is_write;
	logic [4:0]  widx;
	logic        hi_byte;
	logic [7:0]  wdata;

	always_comb begin
		case (state)
			ST_DECIDE: in_decide = 1'b1;
			ST_IDLE:   in_decide = 1'b0;
			default:   in_decide = 1'b0;
		endcase
	end

	assign is_long = (cap_count == `SPI_LEN_CRC);
	assign payload = is_long ? cap_frame[19:4] : cap_frame[15:0];

	crc4_word #(.POLY(CRC_POLY), .N(16)) u_rx_crc (
		.data_i (payload),
		.crc_o  (rx_crc)
	);

	assign len_ok   = (cap_count == `SPI_LEN_BASE) | (is_long & crc_en_i);
	assign crc_ok   = ~is_long | (rx_crc == cap_frame[3:0]);
	assign accept   = len_ok & crc_ok & ~payload[`F_SYNC];
	assign is_write = payload[`F_RW];
	assign widx     = payload[13:9];
	assign hi_byte  = ~payload[8];
	assign wdata    = payload[7:0];

	// Low-power window: outputs up to the angle word and configuration word only
	function automatic logic rd_allowed(input logic [4:0] w, input logic lp);
		rd_allowed = !lp || w == `W_CFG ||
			(w >= `W_OUT_FIRST && w <= `W_LP_RD_END);
	endfunction

	// Read-only words: null, read results and the sensor outputs
	function automatic logic wr_allowed(input logic [4:0] w, input logic lp);
		if (lp)
			wr_allowed = (w == `W_CFG);
		else
			wr_allowed = !(w == `W_NOP || w == `W_RD_MSB || w == `W_RD_LSB ||
				(w >= `W_OUT_FIRST && w <= `W_OUT_LAST));
	endfunction

	logic do_write;
	logic do_read;

	assign do_write = in_decide & accept & is_write & wr_allowed(widx, low_power_i);
	assign do_read  = in_decide & accept & ~is_write;

	// ----------------------------------------
	// Primary registers
	// ----------------------------------------
	logic [15:0] regs [0:31];
	logic        ext_rd_go;
	logic        ext_wr_go;
	logic        rd_kick;
	logic        wr_kick;

	assign rd_kick = do_write & hi_byte & (widx == `W_RD_STAT) & wdata[`EX_GO_BIT];
	assign wr_kick = do_write & hi_byte & (widx == `W_WR_STAT) & wdata[`EX_GO_BIT];

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_rd_go <= 1'b0;
			ext_wr_go <= 1'b0;
		end else begin
			ext_rd_go <= rd_kick;
			ext_wr_go <= wr_kick;
		end
	end

	// ----------------------------------------
	// Extended store
	// ----------------------------------------
	logic [31:0] ext_mem [0:`EXT_DEPTH-1];
	logic [7:0]  rd_ext_addr;
	logic [7:0]  wr_ext_addr;
	logic        rd_hit;
	logic        wr_hit;
	logic [31:0] ext_q;

	assign rd_ext_addr = regs[`W_RD_ADDR][7:0];
	assign wr_ext_addr = regs[`W_WR_ADDR][7:0];
	assign rd_hit      = (rd_ext_addr[7:`EXT_AW] == '0);
	assign wr_hit      = (wr_ext_addr[7:`EXT_AW] == '0);
	assign ext_q       = rd_hit ? ext_mem[rd_ext_addr[`EXT_AW-1:0]] : 32'h00000000;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < `EXT_DEPTH; k++)
				ext_mem[k] <= 32'h00000000;
		end else if (ext_wr_go && wr_hit) begin
			ext_mem[wr_ext_addr[`EXT_AW-1:0]] <= {regs[`W_WR_MSB], regs[`W_WR_LSB]};
		end
	end

	// Byte writes land in one half; the done flag set wins over its clear
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < 32; k++)
				regs[k] <= 16'h0000;
		end else begin
			if (do_write && hi_byte)
				regs[widx][15:8] <= wdata;
			if (do_write && !hi_byte)
				regs[widx][7:0] <= wdata;
			if (rd_kick)
				regs[`W_RD_STAT][0] <= 1'b0;
			if (wr_kick)
				regs[`W_WR_STAT][0] <= 1'b0;
			if (ext_rd_go) begin
				regs[`W_RD_MSB]  <= ext_q[31:16];
				regs[`W_RD_LSB]  <= ext_q[15:0];
				regs[`W_RD_STAT] <= `EX_DONE_VAL;
			end
			if (ext_wr_go)
				regs[`W_WR_STAT] <= `EX_DONE_VAL;
		end
	end

	// ----------------------------------------
	// Answer for the next frame
	// ----------------------------------------
	logic [15:0] word_at;
	logic [15:0] rd_val;
	logic [15:0] after_write;
	logic [15:0] next_tx_data;
	logic [15:0] tx_data;
	logic [3:0]  tx_crc;

	assign word_at      = (widx == `W_ANGLE) ? angle_i : regs[widx];
	assign rd_val       = rd_allowed(widx, low_power_i) ? word_at : 16'h0000;
	assign after_write  = WR_RETURNS_ANGLE ? angle_i : 16'h0000;
	assign next_tx_data = do_read ? rd_val : after_write;

	// A discarded or ignored frame leaves the previous answer standing
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			tx_data <= 16'h0000;
		else if (in_decide && accept)
			tx_data <= next_tx_data;
	end

	crc4_word #(.POLY(CRC_POLY), .N(16)) u_tx_crc (
		.data_i (tx_data),
		.crc_o  (tx_crc)
	);

	assign tx_word = {tx_data, tx_crc};

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	verdict_t next_verdict;

	assign next_verdict = !len_ok || payload[`F_SYNC] ? V_IGNORED :
		!crc_ok ? V_CRC_ERR :
		is_write ? V_WRITE : V_READ;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			frame_done_o <= 1'b0;
			crc_err_o    <= 1'b0;
			verdict_o    <= V_NONE;
		end else begin
			frame_done_o <= in_decide & accept;
			crc_err_o    <= in_decide & len_ok & ~payload[`F_SYNC] & ~crc_ok;
			if (in_decide)
				verdict_o <= next_verdict;
		end
	end

endmodule // spi_register_access_port

// ### tb/spi_port_properties.sv
// Pin-level checks for the SPI register access port.
// Assumes it is bound onto the port; every check runs on the system clock.
`timescale 1ns/100ps
module spi_port_properties (
	input wire logic                   sys_clk_i,
	input wire logic                   rstn_i,
	input wire logic                   sclk_i,
	input wire logic                   cs_n_i,
	input wire logic                   miso_o,
	input wire logic                   miso_oe_o,
	input wire logic                   crc_en_i,
	input wire logic                   frame_done_o,
	input wire logic                   crc_err_o,
	input wire spi_port_pkg::verdict_t verdict_o
);
	import spi_port_pkg::*;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------
	// Frame steps
	// ----------------------------------------
	sequence in_frame_long;
		!cs_n_i [*8];
	endsequence
	sequence sclk_held_high;
		sclk_i && $past(sclk_i) && !cs_n_i && !$past(cs_n_i);
	endsequence
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pulse_excl: assert property (!(frame_done_o && crc_err_o))
		else $error("frame accepted and refused together");
	a_done_single: assert property (frame_done_o |=> !frame_done_o)
		else $error("done pulse longer than one cycle");
	a_err_single: assert property (crc_err_o |=> !crc_err_o)
		else $error("check error pulse longer than one cycle");
	a_done_verdict: assert property (frame_done_o |-> verdict_o inside {V_WRITE, V_READ})
		else $error("done without read or write verdict");
	a_err_verdict: assert property (crc_err_o |-> verdict_o == V_CRC_ERR && crc_en_i)
		else $error("check error without enable or verdict");
	a_commit_late: assert property (frame_done_o |-> cs_n_i && $past(cs_n_i, 3))
		else $error("commit before select rose");
	a_hold_frame: assert property (in_frame_long |=> $stable(verdict_o) && !frame_done_o)
		else $error("verdict moved inside a frame");
	a_idle_quiet: assert property (cs_n_i |-> !miso_oe_o && !miso_o)
		else $error("data line driven while deselected");
	a_miso_on_fall: assert property (sclk_held_high |-> $stable(miso_o))
		else $error("data changed while serial clock high");
	a_oe_driven: assert property (!cs_n_i && !sclk_i && !$past(sclk_i) |-> miso_oe_o)
		else $error("data line not driven after clock fall");
endmodule // spi_port_properties

// ### tb/spi_ctrl_model.sv
// Behavioural mode 3 SPI controller driving the port under test.
// Assumes the bench calls xfer one frame at a time and spaces frames.
`timescale 1ns/100ps
module spi_ctrl_model (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// Bench link runs fast to keep runs short; the port needs only the select spacing
	localparam real HALF = 6.0;
	// Select rises once after time zero so the select-cleared flops start known
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b0;
		mosi_o = 1'b0;
		#1;
		cs_n_o = 1'b1;
	end
	// Bits leave MSB first from bit 19; the clock stands high between frames
	task automatic xfer(input logic [19:0] tx, input int n, output logic [19:0] rx);
		rx = 20'h00000;
		#2.7;
		cs_n_o = 1'b0;
		#(HALF);
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b0;
			mosi_o = tx[19-i];
			#(HALF);
			sclk_o = 1'b1;
			rx[19-i] = miso_i;
			#(HALF);
		end
		cs_n_o = 1'b1;
		// Released line shows the inverse, so a stale bit cannot pass
		mosi_o = ~mosi_o;
	endtask
endmodule // spi_ctrl_model

// ### tb/spi_register_access_port_test.sv
// Self-checking bench for the SPI register access port.
// Assumes the controller model and the property checker compile alongside.
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_register_access_port_test;
	import spi_port_pkg::*;
	localparam logic [15:0] ANG = 16'hc3a5;
	logic        sys_clk;
	logic        rstn;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic        crc_en;
	logic        low_power;
	logic        done;
	logic        err;
	verdict_t    verdict;
	logic        got_done;
	logic        got_err;
	logic [19:0] rx;
	int          fails;
	int          n_checks;
	spi_register_access_port i_spi_register_access_port (
		.sys_clk_i    (sys_clk),
		.rstn_i       (rstn),
		.sclk_i       (sclk),
		.cs_n_i       (cs_n),
		.mosi_i       (mosi),
		.miso_o       (miso),
		.miso_oe_o    (miso_oe),
		.crc_en_i     (crc_en),
		.low_power_i  (low_power),
		.angle_i      (ANG),
		.frame_done_o (done),
		.crc_err_o    (err),
		.verdict_o    (verdict)
	);
	spi_ctrl_model i_spi_ctrl_model (
		.sclk_o (sclk),
		.cs_n_o (cs_n),
		.mosi_o (mosi),
		.miso_i (miso)
	);
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] crc4(input logic [15:0] d);
		logic [3:0] c;
		c = `SPI_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? `SPI_CRC_POLY : 4'h0);
		end
		return c;
	endfunction
	function automatic logic [15:0] rd(input logic [5:0] a);
		return {2'b00, a, 8'h00};
	endfunction
	function automatic logic [15:0] wr(input logic [5:0] a, input logic [7:0] d);
		return {2'b01, a, d};
	endfunction
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Commit lands within 6 cycles of select rising; 12 leaves margin and spacing
	task automatic frame(input logic [15:0] pay, input bit crc, input bit bad);
		i_spi_ctrl_model.xfer({pay, crc4(pay) ^ {3'b000, bad}}, crc ? 20 : 16, rx);
		got_done = 1'b0;
		got_err = 1'b0;
		for (int k = 0; k < 12; k++) begin
			@(posedge sys_clk);
			#1;
			if (done === 1'b1) got_done = 1'b1;
			if (err === 1'b1) got_err = 1'b1;
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_read_write;
		frame(rd(6'h2a), 0, 0);
		chk("first answer", 20'h00000, rx);
		chk("read verdict", {17'h00000, V_READ}, {17'h00000, verdict});
		frame(wr(6'h32, 8'ha5), 0, 0);
		chk("write answer", {ANG, 4'h0}, rx);
		chk("write verdict", {17'h00000, V_WRITE}, {17'h00000, verdict});
		chk("write done", 20'h00001, {19'h00000, got_done});
		frame(wr(6'h33, 8'h3c), 0, 0);
		frame(rd(6'h32), 0, 0);
		chk("after write", 20'h00000, rx);
		frame(rd(6'h00), 0, 0);
		chk("config word", {16'ha53c, 4'h0}, rx);
		$display("t_read_write done");
	endtask
	task automatic t_crc;
		crc_en = 1'b1;
		frame(rd(6'h2a), 1, 0);
		chk("zero word check", {16'h0000, crc4(16'h0000)}, rx);
		frame(rd(6'h00), 1, 0);
		chk("angle check", {ANG, crc4(ANG)}, rx);
		frame(rd(6'h2a), 1, 1);
		chk("bad check flag", 20'h00001, {19'h00000, got_err});
		chk("bad verdict", {17'h00000, V_CRC_ERR}, {17'h00000, verdict});
		frame(rd(6'h00), 1, 0);
		chk("after bad check", {16'h0000, crc4(16'h0000)}, rx);
		$display("t_crc done");
	endtask
	task automatic t_refused;
		crc_en = 1'b0;
		frame(rd(6'h2a), 0, 0);
		frame(rd(6'h32), 1, 0);
		chk("long frame", {17'h00000, V_IGNORED}, {17'h00000, verdict});
		chk("long frame done", 20'h00000, {19'h00000, got_done});
		frame(rd(6'h00), 0, 0);
		chk("after ignored", {ANG, 4'h0}, rx);
		$display("t_refused done");
	endtask
	task automatic t_low_power;
		frame(wr(6'h04, 8'h77), 0, 0);
		low_power = 1'b1;
		frame(wr(6'h05, 8'h66), 0, 0);
		frame(wr(6'h33, 8'h11), 0, 0);
		frame(rd(6'h04), 0, 0);
		frame(rd(6'h32), 0, 0);
		chk("blocked read", 20'h00000, rx);
		frame(rd(6'h00), 0, 0);
		chk("low power config", {16'ha511, 4'h0}, rx);
		low_power = 1'b0;
		frame(rd(6'h04), 0, 0);
		frame(rd(6'h00), 0, 0);
		chk("write data word", {16'h7700, 4'h0}, rx);
		$display("t_low_power done");
	endtask
	task automatic t_extended;
		frame(wr(6'h03, 8'h05), 0, 0);
		frame(wr(6'h04, 8'hde), 0, 0);
		frame(wr(6'h05, 8'had), 0, 0);
		frame(wr(6'h06, 8'hbe), 0, 0);
		frame(wr(6'h07, 8'hef), 0, 0);
		frame(wr(6'h08, 8'h80), 0, 0);
		frame(wr(6'h0b, 8'h05), 0, 0);
		frame(wr(6'h0c, 8'h80), 0, 0);
		frame(rd(6'h08), 0, 0);
		frame(rd(6'h0c), 0, 0);
		chk("write done flag", {16'h0001, 4'h0}, rx);
		frame(rd(6'h0e), 0, 0);
		chk("read done flag", {16'h0001, 4'h0}, rx);
		frame(rd(6'h10), 0, 0);
		chk("store high word", {16'hdead, 4'h0}, rx);
		frame(rd(6'h00), 0, 0);
		chk("store low word", {16'hbeef, 4'h0}, rx);
		$display("t_extended done");
	endtask
	initial begin
		rstn = 1'b0;
		crc_en = 1'b0;
		low_power = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		t_read_write;
		t_crc;
		t_refused;
		t_low_power;
		t_extended;
		finish_test;
	end
	initial begin
		#50000;
		fails++;
		finish_test;
	end
endmodule // spi_register_access_port_test
bind spi_register_access_port spi_port_properties i_spi_port_properties (
	.sys_clk_i    (sys_clk_i),
	.rstn_i       (rstn_i),
	.sclk_i       (sclk_i),
	.cs_n_i       (cs_n_i),
	.miso_o       (miso_o),
	.miso_oe_o    (miso_oe_o),
	.crc_en_i     (crc_en_i),
	.frame_done_o (frame_done_o),
	.crc_err_o    (crc_err_o),
	.verdict_o    (verdict_o)
);
